// ===== hdl/cpm_pkg.sv
// constants and state type for the entry port mask register bank
package cpm_pkg;
  localparam int N_ENTRIES = 32;
  localparam int N_PORTS = 13;
  localparam int ADDR_BYTES = 6;
  localparam int ENT_IDX_W = 5;
  localparam int PTR_W = 3;
  localparam int PORT_NUM_W = 4;
  // byte addresses on the apb side
  localparam logic [11:0] ENT_BASE = 12'h0900;
  localparam logic [11:0] ENT_END = 12'h0b00;
  localparam logic [11:0] VALID_ADDR = 12'h0b00;
  localparam logic [11:0] CTRL_ADDR = 12'h0b04;
  // word slots inside one 16-byte entry window
  localparam logic [1:0] FLD_MASK_LOW = 2'h0;
  localparam logic [1:0] FLD_MASK_HIGH = 2'h1;
  localparam logic [1:0] FLD_ADDR_BYTE = 2'h2;
  // field positions
  localparam int LOW_PORTS = 8;
  localparam int HI_PTR_LSB = 5;
  localparam int CTRL_SECURE_BIT = 0;
  // reset values
  localparam logic [N_PORTS-1:0] MASK_RST = 13'h0000;
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic [PTR_W-1:0] PTR_LAST = 3'h5;
  localparam logic [N_ENTRIES-1:0] VALID_RST = 32'h0000_0000;

  typedef struct packed {
    logic [N_ENTRIES-1:0][N_PORTS-1:0] mask;
    logic [N_ENTRIES-1:0][8*ADDR_BYTES-1:0] addr;
    logic [N_ENTRIES-1:0][PTR_W-1:0] ptr;
    logic [N_ENTRIES-1:0] valid;
    logic secure_on;
    logic [31:0] rdata;
    logic slverr;
    logic match;
    logic match_vld;
  } cpm_state_t;
endpackage

// ===== hdl/cpm_match.sv
// per-entry station address comparison gated by port membership
`timescale 1ns/1ps
`default_nettype none
module cpm_match #(
  parameter int N_ENT = cpm_pkg::N_ENTRIES,
  parameter int N_PORT = cpm_pkg::N_PORTS,
  parameter int AW = 8 * cpm_pkg::ADDR_BYTES
) (
  input wire logic [N_ENT-1:0][N_PORT-1:0] mask_in,
  input wire logic [N_ENT-1:0][AW-1:0] addr_in,
  input wire logic [N_ENT-1:0] valid_in,
  input wire logic enable_in,
  input wire logic [AW-1:0] station_in,
  input wire logic [cpm_pkg::PORT_NUM_W-1:0] port_in,
  output logic hit_out
);
  import cpm_pkg::*;
  logic [N_PORT-1:0] port_sel;
  logic [N_ENT-1:0] ent_hit;

  // ports are numbered from one; anything outside 1..N_PORT selects nothing
  always_comb begin
    port_sel = '0;
    if (port_in != '0 && 32'(port_in) <= N_PORT) begin
      port_sel[port_in - 4'h1] = 1'b1;
    end
  end

  generate
    for (genvar e = 0; e < N_ENT; e++) begin : g_ent
      // valid flag and security start both needed
      assign ent_hit[e] = valid_in[e] && enable_in && (addr_in[e] == station_in) &&
                          |(mask_in[e] & port_sel);
    end
  endgenerate

  assign hit_out = |ent_hit;
endmodule // cpm_match
`default_nettype wire

// ===== hdl/cpm_bank.sv
// entry port mask register bank with apb access and security match
`timescale 1ns/1ps
`default_nettype none
// How it works
// - thirty-two independent mask pairs, one per entry
// - any entry may serve any port set
// - several mask bits make address multi-port
// - one port may own several entries
// - associations come only from software-written masks
// - high byte bits 0-4 are ports 9-13
// - high byte bits 5-7 read-only entry pointer
// - masks live in paged space beside addresses
// - compare only valid entries after security start
module cpm_bank (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic check_strobe_in,
  input wire logic [8*cpm_pkg::ADDR_BYTES-1:0] station_in,
  input wire logic [cpm_pkg::PORT_NUM_W-1:0] port_in,
  output logic match_out,
  output logic match_valid_out
);
  import cpm_pkg::*;

  cpm_state_t st;
  cpm_state_t next_st;
  logic [11:0] ent_off;
  logic in_ent;
  logic [ENT_IDX_W-1:0] ent_idx;
  logic [1:0] fld;
  logic is_lo;
  logic is_hi;
  logic is_ab;
  logic is_valid;
  logic is_ctrl;
  logic mapped;
  logic access;
  logic hit;

  assign ent_off = paddr_in - ENT_BASE;
  assign in_ent = (paddr_in >= ENT_BASE) && (paddr_in < ENT_END) && (paddr_in[1:0] == 2'b00);
  assign ent_idx = ent_off[8:4];
  assign fld = ent_off[3:2];
  // paged placement of the mask pair next to the address byte port
  assign is_lo = in_ent && fld == FLD_MASK_LOW;
  assign is_hi = in_ent && fld == FLD_MASK_HIGH;
  assign is_ab = in_ent && fld == FLD_ADDR_BYTE;
  assign is_valid = paddr_in == VALID_ADDR;
  assign is_ctrl = paddr_in == CTRL_ADDR;
  assign mapped = is_lo || is_hi || is_ab || is_valid || is_ctrl;
  assign access = psel_in && penable_in;

  cpm_match u_cpm_match (
    .mask_in(st.mask),
    .addr_in(st.addr),
    .valid_in(st.valid),
    .enable_in(st.secure_on),
    .station_in(station_in),
    .port_in(port_in),
    .hit_out(hit)
  );

  always_comb begin
    next_st = st;
    // read data is prepared in the setup cycle so it comes from a flop
    if (psel_in && !penable_in) begin
      next_st.rdata = 32'h0000_0000;
      next_st.slverr = !mapped;
      if (is_lo) begin
        next_st.rdata[LOW_PORTS-1:0] = st.mask[ent_idx][LOW_PORTS-1:0];
      end else if (is_hi) begin
        next_st.rdata[HI_PTR_LSB-1:0] = st.mask[ent_idx][N_PORTS-1:LOW_PORTS];
        next_st.rdata[HI_PTR_LSB +: PTR_W] = st.ptr[ent_idx];
      end else if (is_ab) begin
        next_st.rdata[7:0] = st.addr[ent_idx][{st.ptr[ent_idx], 3'b000} +: 8];
      end else if (is_valid) begin
        next_st.rdata = st.valid;
      end else if (is_ctrl) begin
        next_st.rdata[CTRL_SECURE_BIT] = st.secure_on;
      end
    end
    if (access) begin
      if (pwrite_in && is_lo) begin
        next_st.mask[ent_idx][LOW_PORTS-1:0] = pwdata_in[LOW_PORTS-1:0];
      end
      // pointer bits of the high byte are dropped on write
      if (pwrite_in && is_hi) begin
        next_st.mask[ent_idx][N_PORTS-1:LOW_PORTS] = pwdata_in[HI_PTR_LSB-1:0];
      end
      // each byte access walks the pointer through the six address bytes
      if (is_ab) begin
        if (pwrite_in) begin
          next_st.addr[ent_idx][{st.ptr[ent_idx], 3'b000} +: 8] = pwdata_in[7:0];
        end
        next_st.ptr[ent_idx] = (st.ptr[ent_idx] == PTR_LAST) ? PTR_RST : st.ptr[ent_idx] + 3'h1;
      end
      // whole-word write: software must read-modify-write to keep other entries valid
      if (pwrite_in && is_valid) begin
        next_st.valid = pwdata_in;
      end
      if (pwrite_in && is_ctrl) begin
        next_st.secure_on = pwdata_in[CTRL_SECURE_BIT];
      end
    end
    next_st.match_vld = check_strobe_in;
    next_st.match = check_strobe_in && hit;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st.mask <= {N_ENTRIES{MASK_RST}};
      st.addr <= '0;
      st.ptr <= {N_ENTRIES{PTR_RST}};
      st.valid <= VALID_RST;
      st.secure_on <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.slverr <= 1'b0;
      st.match <= 1'b0;
      st.match_vld <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // zero wait states: every access phase completes in one cycle
  assign pready_out = 1'b1;
  assign prdata_out = st.rdata;
  assign pslverr_out = access && st.slverr;
  assign match_out = st.match;
  assign match_valid_out = st.match_vld;

  // checks
  logic wr_lo;
  logic wr_hi;
  logic ab_acc;
  logic mask_wr;
  logic [5:0] ab_pos;
  assign wr_lo = access && pwrite_in && is_lo;
  assign wr_hi = access && pwrite_in && is_hi;
  assign ab_acc = access && is_ab;
  assign mask_wr = wr_lo || wr_hi;
  assign ab_pos = {st.ptr[ent_idx], 3'h0};

  a_lo_mask_write: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    wr_lo |=> st.mask[$past(ent_idx)][7:0] == $past(pwdata_in[7:0]))
    else $error("low mask byte not stored");
  a_hi_mask_write: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    wr_hi |=> st.mask[$past(ent_idx)][12:8] == $past(pwdata_in[4:0]))
    else $error("high mask bits not stored");
  a_ptr_read_only: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    wr_hi |=> st.ptr == $past(st.ptr))
    else $error("pointer changed by mask write");
  a_hi_ptr_read: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (psel_in && !penable_in && is_hi) |=> prdata_out[7:5] == $past(st.ptr[ent_idx]))
    else $error("pointer not shown in high byte");
  a_ptr_walk: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    ab_acc |=> st.ptr[$past(ent_idx)] ==
      (($past(st.ptr[ent_idx]) == 3'h5) ? 3'h0 : $past(st.ptr[ent_idx]) + 3'h1))
    else $error("address pointer did not advance");
  a_mask_sw_only: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !mask_wr |=> $stable(st.mask))
    else $error("mask changed without a write");
  a_match_gated: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (check_strobe_in && (!st.secure_on || st.valid == 32'h0000_0000)) |=> !match_out)
    else $error("match without security or valid entry");
  a_match_pulse: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    match_out |-> match_valid_out && $past(check_strobe_in))
    else $error("match without strobe");
  a_unmapped_err: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !mapped) ##1 access |-> pslverr_out)
    else $error("unmapped access not refused");
  // the pointer is the only state a read changes, so address reads are not side-effect free
  a_ptr_ab_only: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !ab_acc |=> $stable(st.ptr))
    else $error("pointer moved without an address byte access");
  a_addr_byte_write: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (ab_acc && pwrite_in) |=>
      st.addr[$past(ent_idx)][$past(ab_pos) +: 8] == $past(pwdata_in[7:0]))
    else $error("address byte not stored");
  a_valid_write: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (access && pwrite_in && is_valid) |=> st.valid == $past(pwdata_in))
    else $error("valid flags not stored");
  a_secure_write: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (access && pwrite_in && is_ctrl) |=> st.secure_on == $past(pwdata_in[0]))
    else $error("security start not stored");
  a_err_no_data: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !mapped) |=> prdata_out == 32'h0000_0000)
    else $error("refused access returned data");

  c_multi_port: cover property (@(posedge ref_clk_in) wr_hi && $countones(pwdata_in[4:0]) > 1);
  c_match_hit: cover property (@(posedge ref_clk_in) match_out);
  c_ptr_wrap: cover property (@(posedge ref_clk_in) ab_acc && st.ptr[ent_idx] == 3'h5);
  c_two_entries: cover property (@(posedge ref_clk_in) $countones(st.valid) > 1);
  c_refused_access: cover property (@(posedge ref_clk_in) pslverr_out);
endmodule // cpm_bank
`default_nettype wire

// ===== tb/test_cpm_bank.sv
// self-checking bench for the entry port mask register bank
`timescale 1ns/1ps
`default_nettype none
module test_cpm_bank;
  import cpm_pkg::*;
  logic clk, rstn, psel, pen, pwr, strobe, pready, pslverr, match, match_vld, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] station;
  logic [3:0] port;
  int n_mismatch, samples_checked;
  localparam logic [47:0] ADR_A = 48'h0a1b_2c3d_4e5f;
  localparam logic [47:0] ADR_B = 48'h1234_5678_9abc;

  cpm_bank u_cpm_bank (
    .ref_clk_in(clk),
    .rstn_in(rstn),
    .psel_in(psel),
    .penable_in(pen),
    .pwrite_in(pwr),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .check_strobe_in(strobe),
    .station_in(station),
    .port_in(port),
    .match_out(match),
    .match_valid_out(match_vld)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [11:0] ra(input int e, input logic [1:0] f);
    return ENT_BASE + 12'(e * 16) + {8'h00, f, 2'b00};
  endfunction

  // one idle edge before each setup, so no signal is assigned twice in a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic cmp(input logic [47:0] st, input logic [3:0] p, input logic exp);
    @(posedge clk);
    strobe <= 1'b1;
    station <= st;
    port <= p;
    @(posedge clk);
    strobe <= 1'b0;
    @(negedge clk);
    chk({31'h0, match_vld}, 32'h1);
    chk({31'h0, match}, {31'h0, exp});
    @(negedge clk);
    chk({31'h0, match_vld}, 32'h0);
  endtask

  initial begin
    rstn = 1'b0;
    {psel, pen, pwr, strobe} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    station = 48'h0;
    port = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ra(0, FLD_MASK_HIGH), 32'h0);
    chk(rd, 32'h0);
    for (int e = 0; e < N_ENTRIES; e++) begin
      apb(1'b1, ra(e, FLD_MASK_LOW), 32'(e) ^ 32'h0000_00a5);
      // pointer bits written as ones must not stick
      apb(1'b1, ra(e, FLD_MASK_HIGH), 32'(e) | 32'h0000_00e0);
    end
    for (int e = 0; e < N_ENTRIES; e++) begin
      apb(1'b0, ra(e, FLD_MASK_LOW), 32'h0);
      chk(rd, 32'(e) ^ 32'h0000_00a5);
      apb(1'b0, ra(e, FLD_MASK_HIGH), 32'h0);
      chk(rd, 32'(e));
      chk({31'h0, err}, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra(2, FLD_ADDR_BYTE), {24'h0, ADR_A[8*i +: 8]});
      apb(1'b1, ra(5, FLD_ADDR_BYTE), {24'h0, ADR_B[8*i +: 8]});
      apb(1'b0, ra(2, FLD_MASK_HIGH), 32'h0);
      chk(rd, {24'h0, 3'((i + 1) % 6), 5'h02});
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra(2, FLD_ADDR_BYTE), 32'h0);
      chk(rd, {24'h0, ADR_A[8*i +: 8]});
    end
    apb(1'b1, ra(2, FLD_MASK_LOW), 32'h0000_0004);
    apb(1'b1, ra(2, FLD_MASK_HIGH), 32'h0000_0002);
    apb(1'b1, ra(5, FLD_MASK_LOW), 32'h0000_0004);
    apb(1'b1, ra(5, FLD_MASK_HIGH), 32'h0000_0000);
    apb(1'b1, VALID_ADDR, 32'h0000_0024);
    apb(1'b0, VALID_ADDR, 32'h0);
    chk(rd, 32'h0000_0024);
    cmp(ADR_A, 4'h3, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0001);
    cmp(ADR_A, 4'h3, 1'b1);
    cmp(ADR_A, 4'ha, 1'b1);
    cmp(ADR_A, 4'h4, 1'b0);
    cmp(ADR_B, 4'h3, 1'b1);
    cmp(ADR_B, 4'ha, 1'b0);
    cmp(ADR_A, 4'h0, 1'b0);
    apb(1'b1, VALID_ADDR, 32'h0000_0004);
    cmp(ADR_B, 4'h3, 1'b0);
    cmp(ADR_A, 4'h3, 1'b1);
    // unmapped and unaligned places answer with an error and no data
    apb(1'b1, 12'hc00, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'hc00, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, ra(2, FLD_MASK_LOW) + 12'h001, 32'h0);
    chk({31'h0, err}, 32'h1);
    results();
  end
endmodule // test_cpm_bank
`default_nettype wire
